// *** hw/pwm_seq_pkg.sv ***
// constants, types and helpers shared by the buck pwm sequencer
package pwm_seq_pkg;

  // ---------------------------------------------------------------
  // clock and oscillator timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned FSW_DEF_HZ = 250_000;
  localparam int unsigned FSW_MAX_HZ = 1_000_000;
  localparam logic [7:0] PERIOD_DEF = 8'(CLK_HZ / FSW_DEF_HZ);
  localparam logic [7:0] PERIOD_MIN = 8'(CLK_HZ / FSW_MAX_HZ);
  localparam int unsigned BLANK_NS = 200;
  localparam logic [2:0] BLANK_CYC =
    3'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned SYNC_PW_NS = 110;
  localparam logic [1:0] SYNC_PW_CYC =
    2'((SYNC_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] ECHO_GUARD_CYC = 2'h3;

  // ---------------------------------------------------------------
  // soft-start, skip counter, thermal figures
  // ---------------------------------------------------------------
  localparam logic [6:0] SS_STEPS = 7'h40;
  localparam logic [4:0] SS_STEP_LAST_CYC = 5'h1f;
  localparam int unsigned SS_STEP_UV = 9500;
  localparam int unsigned REF_FINAL_MV = 600;
  localparam logic [2:0] SKIP_MAX = 3'h7;
  localparam int unsigned TSD_TRIP_C = 150;
  localparam int unsigned TSD_RESUME_C = 120;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_DUTY = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [7:0] PERIOD_RST = 8'h14;
  localparam logic [7:0] DUTY_RST = 8'h14;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned ST_MODE_LSB = 0;
  localparam int unsigned ST_SKIP_LSB = 2;
  localparam int unsigned ST_SLAVE_BIT = 5;
  localparam int unsigned ST_FSWRES_BIT = 6;
  localparam int unsigned ST_REF_LSB = 8;
  localparam int unsigned IRQ_OC = 0;
  localparam int unsigned IRQ_TSD = 1;
  localparam int unsigned IRQ_SSDONE = 2;
  localparam int unsigned IRQ_LOCK = 3;
  localparam int unsigned IRQ_W = 4;

  // ---------------------------------------------------------------
  // pin vector positions of the synchronised inputs
  // ---------------------------------------------------------------
  localparam int unsigned PIN_EN = 0;
  localparam int unsigned PIN_TSD = 1;
  localparam int unsigned PIN_OC = 2;
  localparam int unsigned PIN_FSW = 3;
  localparam int unsigned PIN_SYNC = 4;
  localparam int unsigned PIN_W = 5;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_SOFT,
    ST_RUN,
    ST_THERMAL
  } mode_t;

  // duty limited by the soft-start reference fraction step/64
  function automatic logic [7:0] scale_duty(input logic [7:0] duty,
                                            input logic [6:0] step);
    logic [14:0] prod;
    prod = 15'(duty) * 15'(step);
    return prod[13:6];
  endfunction

  // keep a resistor-set period between 1 MHz and just above default
  function automatic logic [7:0] clamp_period(input logic [7:0] per);
    if (per < PERIOD_MIN) begin
      return PERIOD_MIN;
    end
    if (per >= PERIOD_DEF) begin
      return PERIOD_DEF - 8'h01;
    end
    return per;
  endfunction

endpackage

// *** hw/pwm_link_if.sv ***
// signals between the sequencer core, the oscillator and the guard
`timescale 1ns/100ps
`default_nettype none
interface pwm_link_if;
  logic [7:0] period;
  logic sync_s;
  logic [7:0] saw;
  logic cyc_start;
  logic slave;
  logic sync_drive;
  logic lock_event;
  logic run;
  logic want_on;
  logic oc_s;
  logic sw_on;
  logic [2:0] skip_cnt;
  logic oc_event;

  modport osc_mp (
    input period, sync_s,
    output saw, cyc_start, slave, sync_drive, lock_event
  );
  modport guard_mp (
    input cyc_start, run, want_on, oc_s,
    output sw_on, skip_cnt, oc_event
  );
  modport ctl_mp (
    output period, sync_s, run, want_on, oc_s,
    input saw, cyc_start, slave, sync_drive, lock_event,
    input sw_on, skip_cnt, oc_event
  );
endinterface
`default_nettype wire

// *** hw/sync_osc.sv ***
// switching oscillator with half-period sync output and external lock
`timescale 1ns/100ps
`default_nettype none
module sync_osc
  import pwm_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pwm_link_if.osc_mp lk
);
  logic [7:0] saw_ff;
  logic cyc_ff;
  logic [8:0] gap_ff;
  logic prev_ff;
  logic slave_ff;
  logic [1:0] pw_ff;
  logic drive_ff;
  logic [1:0] echo_ff;

  wire ext_rise = lk.sync_s & ~prev_ff & (echo_ff == 2'h0) & ~drive_ff;
  wire fast_edge = ext_rise & (gap_ff < {1'b0, lk.period});
  wire wrap = saw_ff >= lk.period - 8'h01;
  wire restart = wrap | fast_edge;
  wire half_hit = (saw_ff == (lk.period >> 1)) & ~slave_ff;
  wire lost = gap_ff >= {lk.period, 1'b0};
  wire [1:0] nxt_pw = half_hit ? SYNC_PW_CYC :
                      (pw_ff != 2'h0) ? pw_ff - 2'h1 : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saw_ff <= 8'h00;
      cyc_ff <= 1'b0;
      prev_ff <= 1'b0;
      pw_ff <= 2'h0;
      drive_ff <= 1'b0;
    end else begin
      saw_ff <= restart ? 8'h00 : saw_ff + 8'h01;
      cyc_ff <= restart;
      prev_ff <= lk.sync_s;
      pw_ff <= nxt_pw;
      drive_ff <= nxt_pw != 2'h0;
    end
  end

  // lock tracking: faster edges make this end the slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ff <= 9'h1ff;
      slave_ff <= 1'b0;
      echo_ff <= 2'h0;
    end else begin
      gap_ff <= ext_rise ? 9'h000 : (gap_ff == 9'h1ff) ? gap_ff :
                gap_ff + 9'h001;
      if (fast_edge) begin
        slave_ff <= 1'b1;
      end else if (lost) begin
        slave_ff <= 1'b0;
      end
      echo_ff <= drive_ff ? ECHO_GUARD_CYC :
                 (echo_ff != 2'h0) ? echo_ff - 2'h1 : 2'h0;
    end
  end

  assign lk.saw = saw_ff;
  assign lk.cyc_start = cyc_ff;
  assign lk.slave = slave_ff;
  assign lk.sync_drive = drive_ff;
  assign lk.lock_event = fast_edge & ~slave_ff;
endmodule // sync_osc
`default_nettype wire

// *** hw/pulse_guard.sv ***
// on-time gate with current blanking and pulse-skip counter
`timescale 1ns/100ps
`default_nettype none
module pulse_guard
  import pwm_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pwm_link_if.guard_mp lk
);
  logic on_ff;
  logic [2:0] blank_ff;
  logic [2:0] skip_ff;
  logic [2:0] left_ff;
  logic oc_ev_ff;

  wire blank_end = on_ff & (blank_ff == BLANK_CYC - 3'h1);
  wire blanked = blank_ff < BLANK_CYC - 3'h1;
  wire trip_end = blank_end & lk.oc_s;
  wire trip_late = on_ff & ~blanked & ~blank_end & lk.oc_s;
  wire [2:0] skip_up = (skip_ff == SKIP_MAX) ? SKIP_MAX : skip_ff + 3'h1;
  wire [2:0] skip_dn = (skip_ff == 3'h0) ? 3'h0 : skip_ff - 3'h1;
  wire start_on = lk.cyc_start & lk.want_on & (left_ff == 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_ff <= 1'b0;
      blank_ff <= 3'h0;
      skip_ff <= 3'h0;
      left_ff <= 3'h0;
      oc_ev_ff <= 1'b0;
    end else if (!lk.run) begin
      on_ff <= 1'b0;
      blank_ff <= 3'h0;
      skip_ff <= 3'h0;
      left_ff <= 3'h0;
      oc_ev_ff <= 1'b0;
    end else begin
      oc_ev_ff <= trip_end | trip_late;
      if (trip_end) begin
        on_ff <= 1'b0;
        skip_ff <= skip_up;
        left_ff <= skip_up;
      end else if (trip_late || (on_ff && !lk.want_on)) begin
        on_ff <= 1'b0;
      end else if (lk.cyc_start && left_ff != 3'h0) begin
        left_ff <= left_ff - 3'h1;
      end else if (start_on && !on_ff) begin
        on_ff <= 1'b1;
        blank_ff <= 3'h0;
      end
      if (blank_end && !lk.oc_s) begin
        skip_ff <= skip_dn;
      end
      if (on_ff && blanked) begin
        blank_ff <= blank_ff + 3'h1;
      end else if (blank_end) begin
        blank_ff <= BLANK_CYC;
      end
    end
  end

  assign lk.sw_on = on_ff;
  assign lk.skip_cnt = skip_ff;
  assign lk.oc_event = oc_ev_ff;
endmodule // pulse_guard
`default_nettype wire

// *** hw/buck_pwm_control_sequencer.sv ***
// top of the buck pwm control sequencer with apb register access
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module buck_pwm_control_sequencer
  import pwm_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_pin,
  input wire logic thermal_pin,
  input wire logic overcurrent_pin,
  input wire logic fsw_res_pin,
  input wire logic sync_io_pin_i,
  output logic sync_io_pin_o,
  output logic sync_io_pin_oe,
  output logic high_side_switch,
  output logic [6:0] ref_level,
  output logic standby,
  output logic irq
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [PIN_W-1:0] meta_ff;
  logic [PIN_W-1:0] pins_ff;
  wire [PIN_W-1:0] pins_raw = {sync_io_pin_i, fsw_res_pin,
                               overcurrent_pin, thermal_pin, enable_pin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      pins_ff <= '0;
    end else begin
      meta_ff <= pins_raw;
      pins_ff <= meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------
  pwm_link_if lk ();

  sync_osc u_osc (
    .pclk(pclk),
    .presetn(presetn),
    .lk(lk.osc_mp)
  );

  pulse_guard u_guard (
    .pclk(pclk),
    .presetn(presetn),
    .lk(lk.guard_mp)
  );

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic ctrl_en_ff;
  logic [7:0] period_ff;
  logic [7:0] duty_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  wire access = psel & penable;
  wire done = access & pready_ff;
  wire wr_done = done & pwrite;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_period = paddr == ADDR_PERIOD;
  wire hit_duty = paddr == ADDR_DUTY;
  wire hit_status = paddr == ADDR_STATUS;
  wire hit_istat = paddr == ADDR_IRQ_STAT;
  wire hit_imask = paddr == ADDR_IRQ_MASK;
  wire hit_any = hit_ctrl | hit_period | hit_duty | hit_status |
                 hit_istat | hit_imask;

  // ---------------------------------------------------------------
  // operating mode
  // ---------------------------------------------------------------
  mode_t mode_ff;
  mode_t nxt_mode;
  logic [4:0] ss_cyc_ff;
  logic [6:0] ss_step_ff;
  logic standby_ff;
  logic switch_ff;
  logic sync_o_ff;
  logic sync_oe_ff;
  logic irq_ff;

  wire en_on = pins_ff[PIN_EN] & ctrl_en_ff;
  wire hot = pins_ff[PIN_TSD];
  wire ss_tick = (mode_ff == ST_SOFT) & lk.cyc_start;
  wire step_end = ss_tick & (ss_cyc_ff == SS_STEP_LAST_CYC);
  wire ss_done = step_end & (ss_step_ff == SS_STEPS - 7'h01);

  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      ST_STANDBY: begin
        if (en_on && !hot) begin
          nxt_mode = ST_SOFT;
        end
      end
      ST_SOFT, ST_RUN: begin
        if (!en_on) begin
          nxt_mode = ST_STANDBY;
        end else if (hot) begin
          nxt_mode = ST_THERMAL;
        end else if (ss_done) begin
          nxt_mode = ST_RUN;
        end
      end
      ST_THERMAL: begin
        if (!hot) begin
          nxt_mode = en_on ? ST_SOFT : ST_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= ST_STANDBY;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // ---------------------------------------------------------------
  // soft-start staircase
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_cyc_ff <= 5'h00;
      ss_step_ff <= 7'h00;
    end else if (nxt_mode == ST_STANDBY || nxt_mode == ST_THERMAL) begin
      ss_cyc_ff <= 5'h00;
      ss_step_ff <= 7'h00;
    end else if (ss_tick) begin
      ss_cyc_ff <= ss_cyc_ff + 5'h01;
      if (step_end) begin
        ss_step_ff <= ss_step_ff + 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // oscillator and comparator hookup
  // ---------------------------------------------------------------
  wire [7:0] per_eff = pins_ff[PIN_FSW] ? clamp_period(period_ff) :
                       PERIOD_DEF;
  wire [7:0] duty_eff = (mode_ff == ST_RUN) ? duty_ff :
                        scale_duty(duty_ff, ss_step_ff);
  wire running = (mode_ff == ST_SOFT) | (mode_ff == ST_RUN);

  assign lk.period = per_eff;
  assign lk.sync_s = pins_ff[PIN_SYNC];
  assign lk.oc_s = pins_ff[PIN_OC];
  assign lk.run = running;
  assign lk.want_on = lk.saw < duty_eff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_ff <= 1'b1;
      switch_ff <= 1'b0;
      sync_o_ff <= 1'b0;
      sync_oe_ff <= 1'b0;
    end else begin
      standby_ff <= nxt_mode == ST_STANDBY;
      switch_ff <= lk.sw_on & running;
      sync_o_ff <= lk.sync_drive;
      sync_oe_ff <= lk.sync_drive;
    end
  end

  // ---------------------------------------------------------------
  // event status and interrupt
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] ev_set;
  logic [IRQ_W-1:0] ev_clr;
  logic [IRQ_W-1:0] nxt_irq_stat;

  always_comb begin
    ev_set = '0;
    ev_set[IRQ_OC] = lk.oc_event;
    ev_set[IRQ_TSD] = (nxt_mode == ST_THERMAL) & (mode_ff != ST_THERMAL);
    ev_set[IRQ_SSDONE] = ss_done & en_on & ~hot;
    ev_set[IRQ_LOCK] = lk.lock_event;
    ev_clr = (done && !pwrite && hit_istat) ? prdata_ff[IRQ_W-1:0] : '0;
    nxt_irq_stat = (irq_stat_ff & ~ev_clr) | ev_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // ---------------------------------------------------------------
  // apb slave: one wait state, data captured before pready
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[ST_MODE_LSB +: 2] = mode_ff;
    status_word[ST_SKIP_LSB +: 3] = lk.skip_cnt;
    status_word[ST_SLAVE_BIT] = lk.slave;
    status_word[ST_FSWRES_BIT] = pins_ff[PIN_FSW];
    status_word[ST_REF_LSB +: 7] = ss_step_ff;
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux[CTRL_EN_BIT] = ctrl_en_ff;
    end
    if (hit_period) begin
      rd_mux[7:0] = period_ff;
    end
    if (hit_duty) begin
      rd_mux[7:0] = duty_ff;
    end
    if (hit_status) begin
      rd_mux = status_word;
    end
    if (hit_istat) begin
      rd_mux[IRQ_W-1:0] = irq_stat_ff;
    end
    if (hit_imask) begin
      rd_mux[IRQ_W-1:0] = irq_mask_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= access & ~pready_ff;
      if (access && !pready_ff) begin
        pslverr_ff <= ~hit_any;
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
      end else if (done) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_ff <= CTRL_EN_RST;
      period_ff <= PERIOD_RST;
      duty_ff <= DUTY_RST;
      irq_mask_ff <= IRQ_MASK_RST;
    end else if (wr_done) begin
      if (hit_ctrl) begin
        ctrl_en_ff <= pwdata[CTRL_EN_BIT];
      end
      if (hit_period) begin
        period_ff <= pwdata[7:0];
      end
      if (hit_duty) begin
        duty_ff <= pwdata[7:0];
      end
      if (hit_imask) begin
        irq_mask_ff <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sync_io_pin_o = sync_o_ff;
  assign sync_io_pin_oe = sync_oe_ff;
  assign high_side_switch = switch_ff;
  assign ref_level = ss_step_ff;
  assign standby = standby_ff;
  assign irq = irq_ff;

endmodule // buck_pwm_control_sequencer
`default_nettype wire

// *** dv/pwm_seq_props.sv ***
// assertions on the port behaviour of the buck pwm sequencer
`timescale 1ns/100ps
`default_nettype none
module pwm_seq_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enable_pin,
  input wire logic thermal_pin,
  input wire logic sync_io_pin_o,
  input wire logic sync_io_pin_oe,
  input wire logic high_side_switch,
  input wire logic [6:0] ref_level,
  input wire logic standby
);
  logic [15:0] hold_ff;
  logic [6:0] prev_ff;
  logic [15:0] nxt_hold;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // cycles since the reference last moved
  // ------------------------------------------------------------
  assign nxt_hold = (ref_level != prev_ff) ? 16'h0 :
                    (&hold_ff) ? hold_ff : hold_ff + 16'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 16'h0;
      prev_ff <= 7'h0;
    end else begin
      hold_ff <= nxt_hold;
      prev_ff <= ref_level;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_sync_pulse;
    sync_io_pin_o ##1 !sync_io_pin_o;
  endsequence
  property p_apb_wait;
    s_setup |=> !pready ##1 pready;
  endproperty
  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  property p_slverr;
    pslverr |-> pready;
  endproperty
  property p_standby;
    !enable_pin [*8] |-> standby && !high_side_switch;
  endproperty
  property p_thermal;
    thermal_pin [*8] |-> !high_side_switch;
  endproperty
  property p_ref_max;
    ref_level <= 7'h40;
  endproperty
  property p_ref_step;
    ref_level != prev_ff |-> ref_level == prev_ff + 7'h1 || ref_level == 7'h0;
  endproperty
  property p_step_hold;
    ref_level == prev_ff + 7'h1 && prev_ff != 7'h0 |-> hold_ff >= 16'h00f0;
  endproperty
  property p_sync_pw;
    $rose(sync_io_pin_o) |=> s_sync_pulse;
  endproperty
  property p_oe;
    sync_io_pin_oe == sync_io_pin_o;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer not after one wait state");
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready longer than one cycle");
  a_slverr: assert property (p_slverr)
    else $error("pslverr without pready");
  a_standby: assert property (p_standby)
    else $error("enable low but not in standby");
  a_thermal: assert property (p_thermal)
    else $error("switch on while hot");
  a_ref_max: assert property (p_ref_max)
    else $error("reference above full scale");
  a_ref_step: assert property (p_ref_step)
    else $error("reference moved by more than one step");
  a_step_hold: assert property (p_step_hold)
    else $error("soft-start step too short");
  a_sync_pw: assert property (p_sync_pw)
    else $error("sync pulse not two cycles");
  a_oe: assert property (p_oe)
    else $error("sync enable differs from sync level");
endmodule // pwm_seq_props
bind buck_pwm_control_sequencer pwm_seq_props u_pwm_seq_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
  .thermal_pin(thermal_pin), .sync_io_pin_o(sync_io_pin_o),
  .sync_io_pin_oe(sync_io_pin_oe), .high_side_switch(high_side_switch),
  .ref_level(ref_level), .standby(standby)
);
`default_nettype wire

// *** dv/sync_partner.sv ***
// far-side sync source: external clock or second regulator
`timescale 1ns/100ps
`default_nettype none
module sync_partner (
  input wire logic run,
  input wire logic [11:0] half_ns,
  output logic drive
);
  // stands low between frames so the pin reads low while the core is not driving
  // clock half period set by half_ns, faster or slower than the free-running rate
  initial begin
    drive = 1'b0;
    #37;
    forever begin
      wait (run);
      drive = 1'b1;
      #(half_ns);
      drive = 1'b0;
      #(half_ns);
    end
  end
endmodule // sync_partner
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the buck pwm sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pwm_seq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, enable_pin, thermal_pin, overcurrent_pin;
  logic fsw_res_pin, sync_io_pin_o, sync_io_pin_oe, high_side_switch;
  logic standby, irq, part_run, part_drive;
  logic [6:0] ref_level;
  logic [11:0] half_ns;
  wire logic sync_wire = sync_io_pin_oe ? sync_io_pin_o : part_drive;
  int err_count, cmp_count;
  buck_pwm_control_sequencer u_buck_pwm_control_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
    .thermal_pin(thermal_pin), .overcurrent_pin(overcurrent_pin),
    .fsw_res_pin(fsw_res_pin), .sync_io_pin_i(sync_wire),
    .sync_io_pin_o(sync_io_pin_o), .sync_io_pin_oe(sync_io_pin_oe),
    .high_side_switch(high_side_switch), .ref_level(ref_level),
    .standby(standby), .irq(irq));
  sync_partner u_sync_partner (.run(part_run), .half_ns(half_ns),
    .drive(part_drive));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic hang(input string what);
    err_count++;
    $display("BAD %0t timeout %s", $time, what);
    complete_run;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hang("apb");
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rise_gap(input logic sw, output int gap);
    logic p;
    logic c;
    int first;
    p = 1'b1;
    first = -1;
    gap = 0;
    for (int i = 0; i < 400 && gap == 0; i++) begin
      @(posedge pclk);
      c = sw ? high_side_switch : sync_io_pin_o;
      if (c === 1'b1 && p === 1'b0) begin
        if (first < 0) first = i;
        else gap = i - first;
      end
      p = c;
    end
    if (gap == 0) hang("edge");
  endtask
  task automatic wait_ref(input logic [6:0] lvl, output int n);
    n = 0;
    while (ref_level !== lvl && n < 30000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 30000) hang("ref");
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] v;
    logic [7:0] ra[4] = '{ADDR_CTRL, ADDR_PERIOD, ADDR_DUTY, ADDR_IRQ_MASK};
    logic [31:0] rx[4] = '{32'h1, 32'h14, 32'h14, 32'h0};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0, v);
      chk(v, rx[i], "reset value");
    end
    apb(1'b1, 8'h40, 32'hffff_ffff, v);
    chk(last_err, 1'b1, "unmapped write");
    apb(1'b0, 8'h40, 32'h0, v);
    chk({v[30:0], last_err}, 32'h1, "unmapped read");
    chk(standby, 1'b1, "standby at start");
  endtask
  task automatic t_rates;
    logic [31:0] v;
    int g;
    enable_pin <= 1'b1;
    rise_gap(1'b0, g);
    chk(g, PERIOD_DEF, "default period");
    apb(1'b1, ADDR_DUTY, 32'h5, v);
    apb(1'b1, ADDR_PERIOD, 32'ha, v);
    apb(1'b0, ADDR_PERIOD, 32'h0, v);
    chk(v, 32'ha, "period readback");
    fsw_res_pin <= 1'b1;
    rise_gap(1'b0, g);
    rise_gap(1'b0, g);
    chk(g, 10, "resistor period");
    enable_pin <= 1'b0;
    cyc(10);
    chk({standby, high_side_switch, ref_level}, 32'h100, "standby");
    enable_pin <= 1'b1;
  endtask
  task automatic t_soft;
    logic [31:0] v;
    int n;
    wait_ref(7'h2, n);
    wait_ref(7'h3, n);
    chk(n, 32 * 10, "step length");
    wait_ref(SS_STEPS, n);
    cyc(5);
    apb(1'b0, ADDR_STATUS, 32'h0, v);
    chk({v[14:8], v[1:0]}, {SS_STEPS, ST_RUN}, "ramp done");
    chk(irq, 1'b0, "masked irq");
    apb(1'b1, ADDR_IRQ_MASK, 32'h4, v);
    cyc(3);
    chk(irq, 1'b1, "irq raised");
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, v);
    chk(v[IRQ_SSDONE], 1'b1, "ramp event");
    cyc(3);
    chk(irq, 1'b0, "irq cleared");
  endtask
  task automatic t_sync;
    logic [31:0] v;
    int g;
    half_ns <= 12'h190;
    part_run <= 1'b1;
    cyc(100);
    rise_gap(1'b1, g);
    chk(g, 8, "locked period");
    apb(1'b0, ADDR_STATUS, 32'h0, v);
    chk({v[ST_SLAVE_BIT], sync_io_pin_oe}, 32'h2, "slave");
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, v);
    chk(v[IRQ_LOCK], 1'b1, "lock event");
    part_run <= 1'b0;
    cyc(60);
    half_ns <= 12'h320;
    part_run <= 1'b1;
    cyc(100);
    apb(1'b0, ADDR_STATUS, 32'h0, v);
    chk(v[ST_SLAVE_BIT], 1'b0, "slow clock ignored");
    part_run <= 1'b0;
  endtask
  task automatic t_fault;
    logic [31:0] s;
    int n;
    int run;
    int mx;
    int ln;
    overcurrent_pin <= 1'b1;
    run = 0;
    mx = 0;
    ln = 0;
    for (int i = 0; i < 80; i++) begin
      @(posedge pclk);
      if (high_side_switch === 1'b1) begin
        run++;
        if (run > mx) mx = run;
      end else if (run > 0) begin
        ln = run;
        run = 0;
      end
    end
    chk(mx < 5, 1'b1, "pulse cut short");
    chk(ln, BLANK_CYC, "blanking kept");
    cyc(600);
    apb(1'b0, ADDR_STATUS, 32'h0, s);
    chk(s[4:2], SKIP_MAX, "skip saturates");
    overcurrent_pin <= 1'b0;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0, s);
      n++;
    end while (s[4:2] === SKIP_MAX && n < 100);
    if (n >= 100) hang("skip");
    chk(s[4:2], SKIP_MAX - 3'h1, "skip down one");
    thermal_pin <= 1'b1;
    cyc(10);
    chk(high_side_switch, 1'b0, "hot switch");
    apb(1'b0, ADDR_STATUS, 32'h0, s);
    chk(s[4:0], {3'h0, ST_THERMAL}, "hot mode");
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, s);
    chk(s, 32'h3, "fault events");
    thermal_pin <= 1'b0;
    cyc(10);
    apb(1'b0, ADDR_STATUS, 32'h0, s);
    chk({s[14:8], s[1:0]}, {7'h0, ST_SOFT}, "ramp restart");
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, enable_pin} = 5'h0;
    {thermal_pin, overcurrent_pin, fsw_res_pin, part_run} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    half_ns = 12'h190;
    err_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_rates;
    t_soft;
    t_sync;
    t_fault;
    complete_run;
  end
endmodule // tb
`default_nettype wire
